// [logic/timer_channel_control.sv]
// Functional notes
// - Control bit 7 enables the timer; zero stops it to save power.
// - Fast clear: capture-channel read or compare-channel write clears its flag.
// - Fast clear: any counter access clears the overflow flag.
// - Toggle-on-overflow bits invert a channel's compare pin at each overflow.
// - Overflow toggling only affects channels configured for output compare.
// - Overflow toggle beats a forced compare on the same pin.
// - Action register 0x28: mode bits 7,5,3,1, level bits 6,4,2,0.
// - Pair 00 disconnect, 01 toggle, 10 drive zero, 11 drive one.
// - Any nonzero mode/level pair makes an output-compare channel's pin a timer output.
// - Edge register 0x29: 00 off, 01 rising, 10 falling, 11 both edges.
// - Channel interrupt enables gate channel flags onto the interrupt request.
// - Offsets decode relative to base 0x200 and base 0x300.
// - Capture or compare event sets the channel's event flag.
// - Without fast clear, flags clear only by writing one.
// - Overflow flag sets when the 16-bit counter rolls from all ones to zero.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module timer_channel_control #(
    parameter int CHANNELS = 4,
    parameter int COUNT_W = 16
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [CHANNELS-1:0] pin_in_i,
    output logic [CHANNELS-1:0] pin_out_o,
    output logic [CHANNELS-1:0] pin_oe_n_o,
    output logic irq_o
);
    // ****************************************************************
    // Bus decode
    // ****************************************************************
    function automatic logic [7:0] offset_of(input logic [11:0] a);
        offset_of = {2'b00, a[7:2]};
    endfunction
    function automatic logic in_window(input logic [11:0] a);
        in_window = ({a[11:8], 8'h00} == timer_channel_control_pkg::BASE_BLOCKING) ||
                    ({a[11:8], 8'h00} == timer_channel_control_pkg::BASE_NONBLOCK);
    endfunction

    logic access;
    logic wr;
    logic rd;
    logic [7:0] ofs;
    logic hit;
    logic [7:0] wb;
    assign access = psel_i && penable_i && pready_o;
    assign wr = access && pwrite_i;
    assign rd = access && !pwrite_i;
    assign ofs = offset_of(paddr_i);
    assign hit = in_window(paddr_i);
    assign wb = pwdata_i[7:0];

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] sys_ctrl, next_sys_ctrl;
    logic [3:0] ios_sel, next_ios_sel;
    logic [3:0] ch3_mask, next_ch3_mask;
    logic [3:0] ch3_data, next_ch3_data;
    logic [3:0] ovf_toggle, next_ovf_toggle;
    logic [7:0] out_action, next_out_action;
    logic [7:0] edge_sel, next_edge_sel;
    logic [3:0] ch_irq_en, next_ch_irq_en;
    logic [4:0] irq_mask, next_irq_mask;
    logic [3:0] ch_flag, next_ch_flag;
    logic ovf_flag, next_ovf_flag;
    logic [COUNT_W-1:0] count, next_count;
    logic [COUNT_W-1:0] cmp [CHANNELS];
    logic [COUNT_W-1:0] next_cmp [CHANNELS];
    logic [3:0] pin_q, next_pin_q;
    logic [3:0] pin_prev, next_pin_prev;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_irq;

    logic enabled;
    logic ffca;
    logic overflow;
    logic [3:0] match;
    logic [3:0] capture;
    logic [3:0] force_hit;
    logic count_access;
    logic [3:0] ch_rd;
    logic [3:0] ch_wr;
    assign enabled = sys_ctrl[timer_channel_control_pkg::TEN_BIT];
    assign ffca = sys_ctrl[timer_channel_control_pkg::FFCA_BIT];
    assign overflow = enabled && (count == {COUNT_W{1'b1}});
    assign count_access = access && hit &&
        (ofs == timer_channel_control_pkg::OFS_COUNT_HI ||
         ofs == timer_channel_control_pkg::OFS_COUNT_LO);

    // ****************************************************************
    // Channel events
    // ****************************************************************
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            logic rise;
            logic fall;
            logic [7:0] o_hi;
            rise = pin_in_i[i] && !pin_prev[i];
            fall = !pin_in_i[i] && pin_prev[i];
            o_hi = 8'(timer_channel_control_pkg::OFS_CH0_HI + 8'(2 * i));
            match[i] = enabled && ios_sel[i] && (count == cmp[i]);
            capture[i] = enabled && !ios_sel[i] &&
                ((edge_sel[2*i] && rise) || (edge_sel[2*i+1] && fall));
            force_hit[i] = wr && hit && (ofs == timer_channel_control_pkg::OFS_FORCE) &&
                wb[i] && ios_sel[i];
            ch_rd[i] = rd && hit && (ofs == o_hi || ofs == 8'(o_hi + 8'h01));
            ch_wr[i] = wr && hit && (ofs == o_hi || ofs == 8'(o_hi + 8'h01));
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_sys_ctrl = sys_ctrl;
        next_ios_sel = ios_sel;
        next_ch3_mask = ch3_mask;
        next_ch3_data = ch3_data;
        next_ovf_toggle = ovf_toggle;
        next_out_action = out_action;
        next_edge_sel = edge_sel;
        next_ch_irq_en = ch_irq_en;
        next_irq_mask = irq_mask;
        next_ch_flag = ch_flag;
        next_ovf_flag = ovf_flag;
        next_count = enabled ? COUNT_W'(count + 1'b1) : count;
        next_cmp = cmp;
        next_pin_q = pin_q;
        next_pin_prev = pin_in_i;
        next_prdata = 32'h0000_0000;
        next_pready = psel_i && !pready_o;
        // Clears first, so a same-cycle set below wins
        if (wr && hit && ofs == timer_channel_control_pkg::OFS_CH_FLAGS)
            next_ch_flag = ch_flag & ~wb[3:0];
        if (wr && hit && ofs == timer_channel_control_pkg::OFS_OVF_FLAGS &&
            wb[timer_channel_control_pkg::TOF_BIT])
            next_ovf_flag = 1'b0;
        if (wr && hit && ofs == timer_channel_control_pkg::OFS_STATUS) begin
            next_ch_flag = next_ch_flag & ~wb[3:0];
            if (wb[timer_channel_control_pkg::IRQ_OVF_BIT])
                next_ovf_flag = 1'b0;
        end
        if (ffca) begin
            next_ch_flag = next_ch_flag & ~((ch_rd & ~ios_sel) | (ch_wr & ios_sel));
            if (count_access)
                next_ovf_flag = 1'b0;
        end
        // Output actions: compare or force, then channel 3 mask data, then overflow toggle on top
        for (int i = 0; i < CHANNELS; i++) begin
            logic [1:0] act;
            act = {out_action[2*i+1], out_action[2*i]};
            if ((match[i] || force_hit[i]) && !(ch3_mask[i] && match[3])) begin
                case (act)
                    2'b01: next_pin_q[i] = !pin_q[i];
                    2'b10: next_pin_q[i] = 1'b0;
                    2'b11: next_pin_q[i] = 1'b1;
                    default: next_pin_q[i] = pin_q[i];
                endcase
            end
            if (match[3] && ch3_mask[i] && ios_sel[i])
                next_pin_q[i] = ch3_data[i];
            if (overflow && ovf_toggle[i] && ios_sel[i])
                next_pin_q[i] = !pin_q[i];
        end
        // Forced compare sets no flag
        next_ch_flag = next_ch_flag | match | capture;
        if (overflow)
            next_ovf_flag = 1'b1;
        if (wr && hit) begin
            case (ofs)
                timer_channel_control_pkg::OFS_IOS_SEL: next_ios_sel = wb[3:0];
                timer_channel_control_pkg::OFS_CH3_MASK: next_ch3_mask = wb[3:0];
                timer_channel_control_pkg::OFS_CH3_DATA: next_ch3_data = wb[3:0];
                timer_channel_control_pkg::OFS_COUNT_HI: next_count[15:8] = wb;
                timer_channel_control_pkg::OFS_COUNT_LO: next_count[7:0] = wb;
                timer_channel_control_pkg::OFS_SYS_CTRL_ONE: next_sys_ctrl = wb & 8'h90;
                timer_channel_control_pkg::OFS_OVF_TOGGLE: next_ovf_toggle = wb[3:0];
                timer_channel_control_pkg::OFS_OUT_ACTION: next_out_action = wb;
                timer_channel_control_pkg::OFS_EDGE_SEL: next_edge_sel = wb;
                timer_channel_control_pkg::OFS_CH_IRQ_EN: next_ch_irq_en = wb[3:0];
                timer_channel_control_pkg::OFS_MASK: next_irq_mask = wb[4:0];
                default: begin
                    for (int i = 0; i < CHANNELS; i++) begin
                        if (ofs == 8'(timer_channel_control_pkg::OFS_CH0_HI + 8'(2 * i)))
                            next_cmp[i][15:8] = wb;
                        if (ofs == 8'(timer_channel_control_pkg::OFS_CH0_HI + 8'(2 * i + 1)))
                            next_cmp[i][7:0] = wb;
                    end
                end
            endcase
        end
        // Capture overrides a same-cycle software write of the data word
        for (int i = 0; i < CHANNELS; i++)
            if (capture[i])
                next_cmp[i] = count;
        if (psel_i && !penable_i && !pwrite_i && hit) begin
            case (ofs)
                timer_channel_control_pkg::OFS_IOS_SEL: next_prdata = {28'h0, ios_sel};
                timer_channel_control_pkg::OFS_CH3_MASK: next_prdata = {28'h0, ch3_mask};
                timer_channel_control_pkg::OFS_CH3_DATA: next_prdata = {28'h0, ch3_data};
                timer_channel_control_pkg::OFS_COUNT_HI: next_prdata = {24'h0, count[15:8]};
                timer_channel_control_pkg::OFS_COUNT_LO: next_prdata = {24'h0, count[7:0]};
                timer_channel_control_pkg::OFS_SYS_CTRL_ONE: next_prdata = {24'h0, sys_ctrl};
                timer_channel_control_pkg::OFS_OVF_TOGGLE: next_prdata = {28'h0, ovf_toggle};
                timer_channel_control_pkg::OFS_OUT_ACTION: next_prdata = {24'h0, out_action};
                timer_channel_control_pkg::OFS_EDGE_SEL: next_prdata = {24'h0, edge_sel};
                timer_channel_control_pkg::OFS_CH_IRQ_EN: next_prdata = {28'h0, ch_irq_en};
                timer_channel_control_pkg::OFS_CH_FLAGS: next_prdata = {28'h0, ch_flag};
                timer_channel_control_pkg::OFS_OVF_FLAGS: next_prdata = {24'h0, ovf_flag, 7'h0};
                timer_channel_control_pkg::OFS_STATUS: next_prdata = {27'h0, ovf_flag, ch_flag};
                timer_channel_control_pkg::OFS_MASK: next_prdata = {27'h0, irq_mask};
                default: begin
                    for (int i = 0; i < CHANNELS; i++) begin
                        if (ofs == 8'(timer_channel_control_pkg::OFS_CH0_HI + 8'(2 * i)))
                            next_prdata = {24'h0, cmp[i][15:8]};
                        if (ofs == 8'(timer_channel_control_pkg::OFS_CH0_HI + 8'(2 * i + 1)))
                            next_prdata = {24'h0, cmp[i][7:0]};
                    end
                end
            endcase
        end else if (pready_o) begin
            next_prdata = prdata_o;
        end
        // Interrupt: per-channel enable gates, then the status mask
        next_irq = |({ovf_flag, ch_flag & ch_irq_en} & irq_mask);
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sys_ctrl <= timer_channel_control_pkg::CTRL_RESET;
            ios_sel <= 4'h0;
            ch3_mask <= 4'h0;
            ch3_data <= 4'h0;
            ovf_toggle <= 4'h0;
            out_action <= timer_channel_control_pkg::CTRL_RESET;
            edge_sel <= timer_channel_control_pkg::CTRL_RESET;
            ch_irq_en <= 4'h0;
            irq_mask <= 5'h00;
            ch_flag <= 4'h0;
            ovf_flag <= 1'b0;
            count <= timer_channel_control_pkg::COUNT_RESET;
            for (int i = 0; i < CHANNELS; i++)
                cmp[i] <= timer_channel_control_pkg::COUNT_RESET;
            pin_q <= 4'h0;
            pin_prev <= 4'h0;
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            irq_o <= 1'b0;
            pin_out_o <= 4'h0;
            pin_oe_n_o <= 4'hF;
            pslverr_o <= 1'b0;
        end else begin
            sys_ctrl <= next_sys_ctrl;
            ios_sel <= next_ios_sel;
            ch3_mask <= next_ch3_mask;
            ch3_data <= next_ch3_data;
            ovf_toggle <= next_ovf_toggle;
            out_action <= next_out_action;
            edge_sel <= next_edge_sel;
            ch_irq_en <= next_ch_irq_en;
            irq_mask <= next_irq_mask;
            ch_flag <= next_ch_flag;
            ovf_flag <= next_ovf_flag;
            count <= next_count;
            cmp <= next_cmp;
            pin_q <= next_pin_q;
            pin_prev <= next_pin_prev;
            prdata_o <= next_prdata;
            pready_o <= next_pready;
            irq_o <= next_irq;
            pin_out_o <= next_pin_q;
            pslverr_o <= 1'b0;
            for (int i = 0; i < CHANNELS; i++)
                pin_oe_n_o[i] <= !(next_ios_sel[i] &&
                    ((|next_out_action[2*i +: 2]) || next_ch3_mask[i]));
        end
    end
    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_wrap;
        sys_ctrl[7] && count == 16'hFFFF && !count_access;
    endsequence
    AST_OVF_SET: assert property (s_wrap |=> ovf_flag && count == 16'h0000)
        else $error("overflow flag not set on wrap");
    AST_HOLD: assert property (!sys_ctrl[7] && !count_access |=> $stable(count))
        else $error("counter moved while disabled");
    AST_TOGGLE: assert property (s_wrap ##0 (ovf_toggle[0] && ios_sel[0]) |=>
        pin_q[0] != $past(pin_q[0]))
        else $error("no toggle on overflow");
    AST_NO_TOG_IC: assert property (!ios_sel[1] |=> $stable(pin_q[1]) || $past(ios_sel[1]))
        else $error("input capture pin toggled");
    AST_FFCA_TOF: assert property (ffca && count_access && !overflow |=> !ovf_flag)
        else $error("fast clear missed overflow flag");
    AST_NO_FFCA: assert property (!ffca && count_access && ovf_flag && !wr |=> ovf_flag)
        else $error("flag cleared without fast clear");
    AST_CAPT: assert property (capture[2] |=> ch_flag[2] && cmp[2] == $past(count))
        else $error("capture not recorded");
    AST_IRQ: assert property (ch_flag[0] && ch_irq_en[0] && irq_mask[0] |=> irq_o)
        else $error("interrupt not raised");
    AST_OE: assert property (ios_sel[1] && out_action[3:2] != 2'b00 |-> !pin_oe_n_o[1])
        else $error("pin not driven");
endmodule
`default_nettype wire

// [pkg/timer_channel_control_pkg.sv]
`default_nettype none
package timer_channel_control_pkg;
    // Register offsets, relative to either window base
    localparam logic [7:0] OFS_IOS_SEL = 8'h20;
    localparam logic [7:0] OFS_FORCE = 8'h21;
    localparam logic [7:0] OFS_CH3_MASK = 8'h22;
    localparam logic [7:0] OFS_CH3_DATA = 8'h23;
    localparam logic [7:0] OFS_COUNT_HI = 8'h24;
    localparam logic [7:0] OFS_COUNT_LO = 8'h25;
    localparam logic [7:0] OFS_SYS_CTRL_ONE = 8'h26;
    localparam logic [7:0] OFS_OVF_TOGGLE = 8'h27;
    localparam logic [7:0] OFS_OUT_ACTION = 8'h28;
    localparam logic [7:0] OFS_EDGE_SEL = 8'h29;
    localparam logic [7:0] OFS_CH_IRQ_EN = 8'h2A;
    localparam logic [7:0] OFS_CH_FLAGS = 8'h2C;
    localparam logic [7:0] OFS_OVF_FLAGS = 8'h2D;
    localparam logic [7:0] OFS_CH0_HI = 8'h2E;
    localparam logic [7:0] OFS_STATUS = 8'h36;
    localparam logic [7:0] OFS_MASK = 8'h37;
    // Window bases in the global space
    localparam logic [11:0] BASE_BLOCKING = 12'h200;
    localparam logic [11:0] BASE_NONBLOCK = 12'h300;
    // Field positions
    localparam int TEN_BIT = 7;
    localparam int FFCA_BIT = 4;
    localparam int TOF_BIT = 7;
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    // Interrupt status layout: channel flags 3..0, overflow in bit 4
    localparam int IRQ_OVF_BIT = 4;
endpackage
`default_nettype wire

// [bench/timer_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Far-side circuit on the four channel pins
// ****************************************
module timer_pin_model (
    input wire logic [3:0] ext_lvl_i,
    input wire logic [3:0] pin_out_i,
    input wire logic [3:0] pin_oe_n_i,
    output logic [3:0] pin_in_o
);
    // The outside driver is weak: a pin the timer drives shows the timer's level
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            pin_in_o[n] = pin_oe_n_i[n] ? ext_lvl_i[n] : pin_out_i[n];
        end
    end
endmodule
`default_nettype wire

// [bench/timer_channel_control_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("Error %0t: got %h expected %h", $time, got, exp); end end
module timer_channel_control_tb_top;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, irq;
    logic [3:0] ext_lvl = 4'h0, pin_in, pin_out, pin_oe_n;
    logic [31:0] seed = 32'hCAD3006F;
    int error_cnt = 0, num_checks = 0;
    int model [int];
    int exp_flags;

    always #50 core_clk_i = ~core_clk_i;

    timer_channel_control DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pin_in_i(pin_in),
        .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n), .irq_o(irq));
    timer_pin_model pins (.ext_lvl_i(ext_lvl), .pin_out_i(pin_out), .pin_oe_n_i(pin_oe_n),
        .pin_in_o(pin_in));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [11:0] ra(input logic [11:0] b, input logic [7:0] o);
        return b + {2'b00, o, 2'b00};
    endfunction
    // Reference edge detector: which channels see a capture for one edge on all pins
    function automatic int hits(input int sel, input int rising);
        int r;
        r = 0;
        for (int n = 0; n < 4; n++) begin
            if (rising != 0 && ((sel >> (2 * n)) & 1) != 0) r |= 1 << n;
            if (rising == 0 && ((sel >> (2 * n + 1)) & 1) != 0) r |= 1 << n;
        end
        return r;
    endfunction
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        @(posedge core_clk_i);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge core_clk_i);
        end
        if (n == 20) begin
            error_cnt++;
            $display("Error %0t: no bus answer", $time);
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never re-drives psel in this step
        @(posedge core_clk_i);
    endtask
    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        apb(1'b1, ra(timer_channel_control_pkg::BASE_BLOCKING, o), {24'h000000, d});
    endtask
    task automatic rd(input logic [7:0] o);
        apb(1'b0, ra(timer_channel_control_pkg::BASE_NONBLOCK, o), 32'h0000_0000);
    endtask
    task automatic edge_all(input logic [3:0] lvl);
        ext_lvl <= lvl;
        repeat (6) @(posedge core_clk_i);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge core_clk_i);
        error_cnt++;
        end_of_test();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        `CHK(pin_oe_n, 4'hF)
        for (int o = 8'h26; o <= 8'h2A; o++) begin
            rd(o[7:0]);
            `CHK(q[7:0], 8'h00)
        end
        for (int k = 0; k < 8; k++) begin
            seed = xorshift(seed);
            model[k % 2] = seed[7:0];
            wr(8'(8'h28 + k % 2), seed[7:0]);
            rd(8'(8'h28 + k % 2));
            `CHK(q[7:0], model[k % 2][7:0])
        end
        apb(1'b0, 12'h100, 32'h0);
        `CHK(q, 32'h0000_0000)
        `CHK(pslverr, 1'b0)
        $display("test registers done");
        wr(8'h28, 8'h00);
        wr(8'h22, 8'h00);
        wr(8'h29, 8'hE4);
        edge_all(4'hF);
        edge_all(4'h0);
        rd(8'h2C);
        `CHK(q[3:0], 4'h0)
        wr(8'h26, 8'h80);
        edge_all(4'hF);
        exp_flags = hits(8'hE4, 1);
        rd(8'h2C);
        `CHK(q[3:0], exp_flags[3:0])
        wr(8'h37, 8'h0F);
        wr(8'h2A, 8'h02);
        repeat (3) @(posedge core_clk_i);
        `CHK(irq, 1'b1)
        wr(8'h2A, 8'h01);
        repeat (3) @(posedge core_clk_i);
        `CHK(irq, 1'b0)
        wr(8'h2C, 8'h00);
        rd(8'h32);
        rd(8'h2C);
        `CHK(q[3:0], exp_flags[3:0])
        wr(8'h2C, 8'h0F);
        rd(8'h2C);
        `CHK(q[3:0], 4'h0)
        edge_all(4'h0);
        exp_flags = hits(8'hE4, 0);
        rd(8'h2C);
        `CHK(q[3:0], exp_flags[3:0])
        wr(8'h26, 8'h90);
        rd(8'h32);
        rd(8'h2C);
        `CHK(q[3:0], exp_flags[3:0] & 4'h8)
        $display("test capture done");
        wr(8'h26, 8'h80);
        repeat (65600) @(posedge core_clk_i);
        rd(8'h2D);
        `CHK(q[7], 1'b1)
        rd(8'h24);
        rd(8'h2D);
        `CHK(q[7], 1'b1)
        wr(8'h26, 8'h90);
        rd(8'h24);
        rd(8'h2D);
        `CHK(q[7], 1'b0)
        $display("test overflow done");
        wr(8'h20, 8'h0E);
        wr(8'h28, 8'hE4);
        repeat (2) @(posedge core_clk_i);
        `CHK(pin_oe_n, 4'b0001)
        wr(8'h21, 8'h0F);
        `CHK(pin_out[3:2], 2'b10)
        $display("test pin drive done");
        // Channel 0 is a capture channel first: an overflow must not toggle it
        exp_flags = {31'h0, pin_out[0]};
        wr(8'h27, 8'h01);
        wr(8'h25, 8'h00);
        wr(8'h24, 8'hFF);
        repeat (300) @(posedge core_clk_i);
        `CHK(pin_out[0], exp_flags[0])
        wr(8'h20, 8'h0F);
        wr(8'h25, 8'h00);
        wr(8'h24, 8'hFF);
        repeat (300) @(posedge core_clk_i);
        `CHK(pin_out[0], ~exp_flags[0])
        $display("test overflow toggle done");
        end_of_test();
    end
endmodule
`default_nettype wire
